// File: hw/gateway_pkg.sv
// Constants and types shared by the positioning sensor command gateway
package gateway_pkg;
  localparam int          CLK_HZ      = 20_000_000;
  localparam int          BAUD_A      = 57600;
  localparam int          BAUD_B      = 38400;
  localparam int          DIV_W       = 10;
  localparam logic [9:0]  DIV_A       = 10'(CLK_HZ / BAUD_A);
  localparam logic [9:0]  DIV_B       = 10'(CLK_HZ / BAUD_B);
  localparam int          POLL_MS     = 10;
  localparam int          POLL_CYCLES = CLK_HZ / 1000 * POLL_MS;
  localparam int          CMD_W       = 16;
  localparam logic [15:0] A_MASK      = 16'h001f;
  localparam logic [15:0] B_MASK      = 16'h007f;
  localparam logic [3:0]  A_POS_CMD   = 4'h3;
  localparam logic [7:0]  A_BASE      = 8'h01;
  localparam logic [7:0]  B_PREFIX    = 8'hc0;
  localparam logic [7:0]  B_SECOND    = 8'hf1;
  localparam logic [7:0]  B_THIRD     = 8'h31;
  localparam logic [1:0]  A_LAST      = 2'h1;
  localparam logic [1:0]  B_LAST      = 2'h2;
  localparam logic [2:0]  TELE_LAST   = 3'h5;
  localparam int          TELE_W      = 48;
  localparam int          FIFO_DEPTH  = 16;
  localparam logic [7:0]  OFF_CTRL    = 8'h00;
  localparam logic [7:0]  OFF_CMD     = 8'h04;
  localparam logic [7:0]  OFF_STATUS  = 8'h08;
  localparam logic [7:0]  OFF_RX_LO   = 8'h0c;
  localparam logic [7:0]  OFF_RX_HI   = 8'h10;
  localparam logic [7:0]  OFF_LAST    = 8'h14;
  localparam int          CTRL_W      = 3;
  localparam logic [2:0]  CTRL_RESET  = 3'h0;
  localparam int          CTRL_CMD    = 0;
  localparam int          CTRL_POS_B  = 1;
  localparam int          CTRL_OPT    = 2;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SEND = 2'b10} seq_state_t;
endpackage

// File: hw/byte_stream_if.sv
// Valid/ready byte stream between the gateway's own modules
`timescale 1ns/10ps
interface byte_stream_if #(parameter int W = 8) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: hw/byte_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module byte_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic               clk,
  input  wire logic               rst_n,
  byte_stream_if.snk              in_s,
  byte_stream_if.src              out_s,
  output logic [$clog2(DEPTH):0]  level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_reg [DEPTH];
  logic [W-1:0] mem_next [DEPTH];
  logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          push, pop;

  assign in_s.ready  = cnt_reg != (AW+1)'(DEPTH);
  assign out_s.valid = cnt_reg != '0;
  assign out_s.data  = mem_reg[rd_reg];
  assign level       = cnt_reg;
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_comb
  begin
    mem_next = mem_reg;
    if (push)
      mem_next[wr_reg] = in_s.data;
    wr_next  = push ? wr_reg + 1'b1 : wr_reg;
    rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk)
  begin
    mem_reg <= mem_next;
    if (!rst_n)
    begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

// File: hw/serial_port.sv
// 8N1 serial transmitter and receiver with a run-time bit divider
`timescale 1ns/10ps
module serial_port (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [9:0] div,
  byte_stream_if.snk      tx_s,
  input  wire logic       rxd,
  output logic            txd,
  output logic            tx_busy,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  logic [9:0] tc_reg, tc_next, rc_reg, rc_next;
  logic [3:0] tb_reg, tb_next, rb_reg, rb_next;
  logic [8:0] ts_reg, ts_next;
  logic [7:0] rs_reg, rs_next, rd_reg, rd_next;
  logic       txd_reg, txd_next, tbusy_reg, tbusy_next;
  logic       rbusy_reg, rbusy_next, rprev_reg, rv_reg, rv_next;

  assign tx_s.ready = ~tbusy_reg;
  assign txd        = txd_reg;
  assign tx_busy    = tbusy_reg;
  assign rx_valid   = rv_reg;
  assign rx_data    = rd_reg;

  always_comb
  begin
    {tc_next, tb_next, ts_next, txd_next, tbusy_next} =
      {tc_reg, tb_reg, ts_reg, txd_reg, tbusy_reg};
    {rc_next, rb_next, rs_next, rd_next, rbusy_next} =
      {rc_reg, rb_reg, rs_reg, rd_reg, rbusy_reg};
    rv_next = 1'b0;
    if (!tbusy_reg && tx_s.valid)
    begin
      {ts_next, txd_next, tbusy_next} = {1'b1, tx_s.data, 1'b0, 1'b1};
      {tb_next, tc_next} = {4'h0, div - 10'h1};
    end
    else if (tbusy_reg && tc_reg != '0)
      tc_next = tc_reg - 10'h1;
    else if (tbusy_reg && tb_reg == 4'h9)
      tbusy_next = 1'b0;
    else if (tbusy_reg)
    begin
      {ts_next, txd_next} = {1'b1, ts_reg};
      {tb_next, tc_next} = {tb_reg + 4'h1, div - 10'h1};
    end
    // Start on a falling edge, sample mid-bit
    if (!rbusy_reg && rprev_reg && !rxd)
      {rbusy_next, rb_next, rc_next} = {1'b1, 4'h0, div >> 1};
    else if (rbusy_reg && rc_reg != '0)
      rc_next = rc_reg - 10'h1;
    else if (rbusy_reg)
    begin
      rc_next = div - 10'h1;
      rb_next = rb_reg + 4'h1;
      if (rb_reg == 4'h0 && rxd)
        rbusy_next = 1'b0;
      else if (rb_reg == 4'h9)
        {rbusy_next, rv_next, rd_next} = {1'b0, rxd, rxd ? rs_reg : rd_reg};
      else if (rb_reg != 4'h0)
        rs_next = {rxd, rs_reg[7:1]};
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      {tc_reg, tb_reg, ts_reg, txd_reg, tbusy_reg} <= {23'h0, 1'b1, 1'b0};
      {rc_reg, rb_reg, rs_reg, rd_reg, rbusy_reg} <= '0;
      {rprev_reg, rv_reg} <= 2'h2;
    end
    else
    begin
      {tc_reg, tb_reg, ts_reg, txd_reg, tbusy_reg} <=
        {tc_next, tb_next, ts_next, txd_next, tbusy_next};
      {rc_reg, rb_reg, rs_reg, rd_reg, rbusy_reg} <=
        {rc_next, rb_next, rs_next, rd_next, rbusy_next};
      {rprev_reg, rv_reg} <= {rxd, rv_next};
    end
  end
endmodule

// File: hw/positioning_sensor_command_gateway.sv
// Control-bit to serial command gateway for positioning sensors, APB side
//
// How it works
// - Position A commands go out as raw bytes, no delimiters or acks.
// - Position A bits 0..4 send two equal bytes 01,02,04,08,10 hex.
// - Position A polls position every 10 ms until another command arrives.
// - Polling resumes only on a new position request or a restart.
// - Position B telegrams are counted as exactly six received bytes.
// - Position B bits 0..6 send C0 F1 31 up to C0 F7 37.
// - Optical sensor ASCII five-digit values are taken without framing.
`timescale 1ns/10ps
module positioning_sensor_command_gateway #(
  parameter int POLL_CYCLES = gateway_pkg::POLL_CYCLES,
  parameter int FIFO_DEPTH  = gateway_pkg::FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  output logic             txd
);
  localparam int PW = $clog2(POLL_CYCLES);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic logic [7:0] cmd_byte(input logic       pos_b,
                                          input logic [3:0] n,
                                          input logic [1:0] i);
    logic [7:0] b;
    b = gateway_pkg::A_BASE << n;
    if (pos_b)
      b = (i == 2'h0) ? gateway_pkg::B_PREFIX :
          (i == 2'h1) ? gateway_pkg::B_SECOND + 8'(n) :
                        gateway_pkg::B_THIRD + 8'(n);
    return b;
  endfunction

  function automatic logic [1:0] cmd_last(input logic pos_b);
    return pos_b ? gateway_pkg::B_LAST : gateway_pkg::A_LAST;
  endfunction

  function automatic logic [3:0] first_set(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int k = 15; k >= 0; k--)
      if (v[k])
        r = 4'(k);
    return r;
  endfunction

  // ************************************************************
  // State
  // ************************************************************
  logic [2:0]            ctrl_reg, ctrl_next;
  logic [15:0]           bits_reg, bits_next, prev_reg;
  logic [15:0]           pend_reg, pend_next;
  gateway_pkg::seq_state_t state_reg, state_next;
  logic [3:0]            cur_reg, cur_next;
  logic                  curb_reg, curb_next;
  logic [1:0]            idx_reg, idx_next;
  logic                  poll_reg, poll_next;
  logic [PW-1:0]         pcnt_reg, pcnt_next;
  logic [47:0]           tsh_reg, tsh_next, tout_reg, tout_next;
  logic [2:0]            tcnt_reg, tcnt_next;
  logic                  tready_reg, tready_next;
  logic [7:0]            last_reg, last_next;
  logic [31:0]           prdata_reg, prdata_next;
  logic                  pready_reg, pready_next;
  logic                  pslverr_reg, pslverr_next;

  logic [15:0]           rise, take, mask, poll_set;
  logic                  pos_b, fire, setup, access, wr_ok, rd_hi;
  logic [9:0]            div;
  logic                  tx_busy, rx_valid;
  logic [7:0]            rx_data;
  logic [LW-1:0]         level;
  logic [31:0]           rd_mux;
  logic                  addr_ok;

  byte_stream_if #(.W(8)) cmd_s ();
  byte_stream_if #(.W(8)) ser_s ();

  assign pos_b = ctrl_reg[gateway_pkg::CTRL_POS_B];
  // Bit rate follows the selector position
  assign div   = pos_b ? gateway_pkg::DIV_B :
                         gateway_pkg::DIV_A;

  // ************************************************************
  // Command FIFO and serial port
  // ************************************************************
  byte_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk   (clk),
    .rst_n (rst_n),
    .in_s  (cmd_s),
    .out_s (ser_s),
    .level (level)
  );

  serial_port u_port (
    .clk      (clk),
    .rst_n    (rst_n),
    .div      (div),
    .tx_s     (ser_s),
    .rxd      (rxd),
    .txd      (txd),
    .tx_busy  (tx_busy),
    .rx_valid (rx_valid),
    .rx_data  (rx_data)
  );

  // ************************************************************
  // Command sequencer and polling
  // ************************************************************
  // Optical sensor takes no commands, so no bit is mapped
  assign mask = ctrl_reg[gateway_pkg::CTRL_OPT] ? 16'h0000 :
                pos_b ? gateway_pkg::B_MASK :
                        gateway_pkg::A_MASK;
  assign rise = bits_reg & ~prev_reg & mask &
                {16{ctrl_reg[gateway_pkg::CTRL_CMD]}};
  assign fire = poll_reg & !pos_b &
                (pcnt_reg == PW'(POLL_CYCLES - 1));
  assign poll_set = fire ? (16'h0001 << gateway_pkg::A_POS_CMD) : 16'h0000;
  assign take = (state_reg == gateway_pkg::ST_IDLE && pend_reg != '0) ?
                (16'h0001 << first_set(pend_reg)) : 16'h0000;

  // Raw bytes only, no delimiters
  assign cmd_s.valid = state_reg == gateway_pkg::ST_SEND;
  assign cmd_s.data  = cmd_byte(curb_reg, cur_reg, idx_reg);

  always_comb
  begin
    state_next = state_reg;
    cur_next   = cur_reg;
    curb_next  = curb_reg;
    idx_next   = idx_reg;
    // A newly risen bit is kept even in the cycle its old copy is taken
    pend_next  = (pend_reg & ~take) | rise | poll_set;
    unique case (state_reg)
      gateway_pkg::ST_IDLE:
        if (take != '0)
        begin
          state_next = gateway_pkg::ST_SEND;
          cur_next   = first_set(pend_reg);
          curb_next  = pos_b;
          idx_next   = 2'h0;
        end
      gateway_pkg::ST_SEND:
        if (cmd_s.ready)
        begin
          if (idx_reg == cmd_last(curb_reg))
            state_next = gateway_pkg::ST_IDLE;
          idx_next = idx_reg + 2'h1;
        end
    endcase
    // Any other position A command stops polling, a position A request restarts it
    poll_next = poll_reg;
    if (!pos_b && rise[gateway_pkg::A_POS_CMD])
      poll_next = 1'b1;
    else if (!pos_b && rise != '0)
      poll_next = 1'b0;
    pcnt_next = (poll_reg && !pos_b && !fire) ? pcnt_reg + PW'(1) : '0;
  end

  // ************************************************************
  // Receive telegram assembly
  // ************************************************************
  always_comb
  begin
    tsh_next    = tsh_reg;
    tout_next   = tout_reg;
    tcnt_next   = pos_b ? tcnt_reg : 3'h0;
    last_next   = last_reg;
    tready_next = tready_reg & ~rd_hi;
    if (rx_valid)
    begin
      last_next = rx_data;
      if (pos_b)
      begin
        tsh_next  = {rx_data, tsh_reg[47:8]};
        tcnt_next = tcnt_reg + 3'h1;
        if (tcnt_reg == gateway_pkg::TELE_LAST)
        begin
          tout_next   = {rx_data, tsh_reg[47:8]};
          tcnt_next   = 3'h0;
          tready_next = 1'b1;
        end
      end
    end
  end

  // ************************************************************
  // APB slave
  // ************************************************************
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready_reg;
  assign wr_ok  = access & pwrite & ~pslverr_reg;
  assign rd_hi  = access & ~pwrite & (paddr == gateway_pkg::OFF_RX_HI);

  always_comb
  begin
    addr_ok = 1'b1;
    unique case (paddr)
      gateway_pkg::OFF_CTRL:   rd_mux = {29'h0, ctrl_reg};
      gateway_pkg::OFF_CMD:    rd_mux = {16'h0, bits_reg};
      gateway_pkg::OFF_STATUS: rd_mux = {16'h0, 8'(level), 4'h0,
                                         ~cmd_s.ready, tx_busy,
                                         tready_reg, poll_reg};
      gateway_pkg::OFF_RX_LO:  rd_mux = tout_reg[31:0];
      gateway_pkg::OFF_RX_HI:  rd_mux = {16'h0, tout_reg[47:32]};
      gateway_pkg::OFF_LAST:   rd_mux = {24'h0, last_reg};
      default:
      begin
        rd_mux  = 32'h0;
        addr_ok = 1'b0;
      end
    endcase
    pready_next  = setup;
    pslverr_next = setup & ~addr_ok;
    prdata_next  = setup ? (pwrite ? 32'h0 : rd_mux) : prdata_reg;
    ctrl_next    = ctrl_reg;
    bits_next    = bits_reg;
    if (wr_ok && paddr == gateway_pkg::OFF_CTRL)
      ctrl_next = pwdata[gateway_pkg::CTRL_W-1:0];
    if (wr_ok && paddr == gateway_pkg::OFF_CMD)
      bits_next = pwdata[15:0];
  end

  // ************************************************************
  // Registers
  // ************************************************************
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ctrl_reg    <= gateway_pkg::CTRL_RESET;
      bits_reg    <= 16'h0;
      prev_reg    <= 16'h0;
      pend_reg    <= 16'h0;
      state_reg   <= gateway_pkg::ST_IDLE;
      cur_reg     <= 4'h0;
      curb_reg    <= 1'b0;
      idx_reg     <= 2'h0;
      poll_reg    <= 1'b1;
      pcnt_reg    <= '0;
      tsh_reg     <= 48'h0;
      tout_reg    <= 48'h0;
      tcnt_reg    <= 3'h0;
      tready_reg  <= 1'b0;
      last_reg    <= 8'h0;
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      bits_reg    <= bits_next;
      prev_reg    <= bits_reg;
      pend_reg    <= pend_next;
      state_reg   <= state_next;
      cur_reg     <= cur_next;
      curb_reg    <= curb_next;
      idx_reg     <= idx_next;
      poll_reg    <= poll_next;
      pcnt_reg    <= pcnt_next;
      tsh_reg     <= tsh_next;
      tout_reg    <= tout_next;
      tcnt_reg    <= tcnt_next;
      tready_reg  <= tready_next;
      last_reg    <= last_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = pready_reg;
  assign pslverr = pslverr_reg;

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_rate_pos_a: assert property (!pos_b |-> div == 10'h15b)
    else $error("position A divider wrong");
  chk_rate_pos_b: assert property (pos_b |-> div == 10'h208)
    else $error("position B divider wrong");
  chk_a_cmd_byte: assert property (
    cmd_s.valid && !curb_reg |-> cmd_s.data == (8'h01 << cur_reg))
    else $error("position A command byte wrong");
  chk_b_cmd_seq: assert property (
    cmd_s.valid && curb_reg && idx_reg == 2'h0 && cmd_s.ready
    |=> cmd_s.valid && cmd_s.data == 8'hf1 + 8'(cur_reg))
    else $error("position B command sequence wrong");
  chk_b_cmd_tail: assert property (
    cmd_s.valid && curb_reg && idx_reg == 2'h2
    |-> cmd_s.data == 8'h31 + 8'(cur_reg))
    else $error("position B last command byte wrong");
  chk_cmd_length: assert property (
    $rose(cmd_s.valid) && !curb_reg && cmd_s.ready ##1 cmd_s.ready
    |=> state_reg == gateway_pkg::ST_IDLE)
    else $error("position A command not two bytes");
  chk_no_spurious: assert property (
    state_reg == gateway_pkg::ST_IDLE && pend_reg == '0 &&
    rise == '0 && !fire |=> pend_reg == '0 && !cmd_s.valid)
    else $error("command without a rising bit");
  chk_poll_fires: assert property (
    fire |=> pend_reg[3] || state_reg == gateway_pkg::ST_SEND)
    else $error("poll request missed");
  chk_poll_stops: assert property (
    !pos_b && rise != '0 && !rise[3] |=> !poll_reg ##1 pcnt_reg == '0)
    else $error("polling did not stop");
  chk_poll_stays: assert property (
    !poll_reg && !rise[3] |=> !poll_reg)
    else $error("polling restarted on its own");
  chk_tele_six: assert property (
    rx_valid && pos_b && tcnt_reg == 3'h5 |=> tready_reg && tcnt_reg == 3'h0)
    else $error("telegram not closed after six bytes");

  cov_a_command: cover property (cmd_s.valid && cmd_s.ready && !curb_reg);
  cov_b_command: cover property (cmd_s.valid && cmd_s.ready && curb_reg);
  cov_poll:      cover property (fire);
  cov_telegram:  cover property ($rose(tready_reg));
  cov_fifo_full: cover property (!cmd_s.ready);
endmodule

// File: testbench/sensor_model.sv
// Behavioural RS 232 sensor facing the gateway's serial lines
`timescale 1ns/10ps
module sensor_model (
  input  wire logic       clk,
  input  wire logic [9:0] bit_div,
  input  wire logic       txd,
  output logic            rxd
);
  logic [7:0] rx_q[$];
  int         frame_errs;
  logic [7:0] sh;

  initial
  begin
    rxd = 1'b1;
    frame_errs = 0;
  end

  // ****************************************
  // Receive 8N1, LSB first, at bit_div cycles a bit
  // ****************************************
  // Raw bytes only, nothing is sent back as acknowledgement
  always
  begin
    @(negedge txd);
    repeat (bit_div / 2) @(posedge clk);
    if (txd === 1'b0)
    begin
      for (int i = 0; i < 8; i++)
      begin
        repeat (bit_div) @(posedge clk);
        sh[i] = txd;
      end
      repeat (bit_div) @(posedge clk);
      if (txd !== 1'b1)
        frame_errs++;
      rx_q.push_back(sh);
    end
  end

  // ****************************************
  // Transmit one unframed 8N1 byte
  // ****************************************
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      rxd <= fr[i];
      repeat (bit_div - 1) @(posedge clk);
    end
  endtask
endmodule

// File: testbench/positioning_sensor_command_gateway_tb_top.sv
// Self-checking bench for the positioning sensor command gateway
`timescale 1ns/10ps
module positioning_sensor_command_gateway_tb_top;
  localparam int POLL = 8000;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rxd;
  logic        txd;
  logic [9:0]  link_div;
  logic [31:0] rd;
  logic        err;
  int          errors;
  int          n_compared;
  int          n;
  logic [7:0]  b_cmd[6] = '{8'hc0, 8'hf1, 8'h31, 8'hc0, 8'hf7, 8'h37};

  positioning_sensor_command_gateway #(
    .POLL_CYCLES (POLL),
    .FIFO_DEPTH  (16)
  ) DUT (
    .clk     (clk),
    .rst_n   (rst_n),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rxd     (rxd),
    .txd     (txd)
  );

  sensor_model sm (
    .clk     (clk),
    .bit_div (link_div),
    .txd     (txd),
    .rxd     (rxd)
  );

  initial
    clk = 1'b0;
  always #25 clk = ~clk;

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      errors++;
      end_sim();
    end
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    repeat (8) @(posedge clk);
    do
    begin
      apb(1'b0, gateway_pkg::OFF_STATUS, 32'h0);
      k++;
    end
    while ((rd & 32'h1f04) !== 32'h0 && k < 10000);
    if ((rd & 32'h1f04) !== 32'h0)
    begin
      errors++;
      end_sim();
    end
    repeat (600) @(posedge clk);
  endtask

  task automatic send_cmd(input logic [31:0] v);
    apb(1'b1, gateway_pkg::OFF_CMD, 32'h0);
    apb(1'b1, gateway_pkg::OFF_CMD, v);
    wait_idle();
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    link_div = gateway_pkg::DIV_A;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    while (sm.rx_q.size() < 1 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    check(32'(n > POLL && n < POLL + 4000), 32'h1);
    apb(1'b0, gateway_pkg::OFF_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, gateway_pkg::OFF_STATUS, 32'h0);
    check(rd & 32'h0000_000b, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, 8'h18, 32'h5);
    check(32'(err), 32'h1);
    wait_idle();
    check(32'(sm.rx_q[0]), 32'h08);
    check(32'(sm.rx_q[1]), 32'h08);
    apb(1'b1, gateway_pkg::OFF_CTRL, 32'h1);
    for (int k = 0; k < 5; k++)
    begin
      sm.rx_q.delete();
      send_cmd((32'h1 << k) | 32'h20);
      check(32'(sm.rx_q[$ - 1]), 32'h1 << k);
      check(32'(sm.rx_q[$]), 32'h1 << k);
      if (k == 1 || k == 2)
        check(sm.rx_q.size(), 2);
      apb(1'b0, gateway_pkg::OFF_STATUS, 32'h0);
      check(rd & 32'h1, 32'(k == 3));
    end
    link_div <= gateway_pkg::DIV_B;
    apb(1'b1, gateway_pkg::OFF_CTRL, 32'h3);
    fork
      for (int i = 0; i < 6; i++)
        sm.send_byte(8'(8'h11 + i));
    join_none
    for (int j = 0; j < 2; j++)
    begin
      sm.rx_q.delete();
      send_cmd(j == 0 ? 32'h1 : 32'hc0);
      check(sm.rx_q.size(), 3);
      for (int i = 0; i < 3; i++)
        check(32'(sm.rx_q[i]), 32'(b_cmd[j * 3 + i]));
    end
    n = 0;
    do
    begin
      apb(1'b0, gateway_pkg::OFF_STATUS, 32'h0);
      n++;
    end
    while (rd[1] !== 1'b1 && n < 20000);
    check(rd & 32'h2, 32'h2);
    apb(1'b0, gateway_pkg::OFF_RX_LO, 32'h0);
    check(rd, 32'h1413_1211);
    apb(1'b0, gateway_pkg::OFF_RX_HI, 32'h0);
    check(rd, 32'h0000_1615);
    apb(1'b0, gateway_pkg::OFF_LAST, 32'h0);
    check(rd, 32'h16);
    apb(1'b0, gateway_pkg::OFF_STATUS, 32'h0);
    check(rd & 32'h2, 32'h0);
    check(sm.frame_errs, 0);
    sm.rx_q.delete();
    apb(1'b1, gateway_pkg::OFF_CTRL, 32'h7);
    send_cmd(32'h1);
    check(sm.rx_q.size(), 0);
    apb(1'b1, gateway_pkg::OFF_CTRL, 32'h3);
    send_cmd(32'h0);
    apb(1'b1, gateway_pkg::OFF_CMD, 32'h7f);
    repeat (40) @(posedge clk);
    apb(1'b0, gateway_pkg::OFF_STATUS, 32'h0);
    check(rd & 32'h1f08, 32'h1008);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, gateway_pkg::OFF_CTRL, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, gateway_pkg::OFF_STATUS, 32'h0);
    check(rd & 32'h1f0f, 32'h1);
    end_sim();
  end
endmodule
